// File: shared/pmf_consts.svh
// Constants of the panel meter menu, filter and scaling block
`ifndef PMF_CONSTS_SVH
`define PMF_CONSTS_SVH
`define PMF_CLK_KHZ       50000
`define PMF_SCROLL_MS     4000
`define PMF_DEBOUNCE_MS   10
`define PMF_RPT_DELAY_MS  500
`define PMF_RPT_PERIOD_MS 100
`define PMF_BLINK_MS      500
`define PMF_OFS_LIM       19999
`define PMF_DISP_MIN      (-19999)
`define PMF_DISP_MAX      99999
`define PMF_IN_MAX        29999
`define PMF_BAND_MAX      199
`define PMF_NUM_MODULES   4
`define PMF_PARAMS_PER_MOD 4
// Register byte offsets
`define PMF_REG_STATUS    12'h000
`define PMF_REG_DISPLAY   12'h004
`define PMF_REG_EDIT      12'h008
`define PMF_REG_CFG_BASE  12'h040
// Configuration entry indexes
`define PMF_P_LEVEL       4'd0
`define PMF_P_BAND        4'd1
`define PMF_P_OFFSET      4'd2
`define PMF_P_STYLE       4'd3
`define PMF_P_SIN1        4'd4
`define PMF_P_SDISP1      4'd5
`define PMF_P_SIN2        4'd6
`define PMF_P_SDISP2      4'd7
`define PMF_P_UFN         4'd8
`define PMF_P_UASSIGN     4'd9
`define PMF_P_UPOL        4'd10
`define PMF_P_SCROLL      4'd11
`define PMF_P_DMASK       4'd12
`define PMF_P_LOCK        4'd13
`define PMF_P_INTENS      4'd14
`define PMF_RST_SIN2      18'sh003E8
`define PMF_RST_SDISP2    18'sh003E8
`endif

// File: shared/pmf_pkg.sv
// Types shared by the panel meter block
package pmf_pkg;
    typedef enum logic [1:0] {
        PMF_DISP  = 2'b00,
        PMF_MENU  = 2'b01,
        PMF_PARAM = 2'b10
    } pmf_mode_t;
    typedef enum logic [3:0] {
        PMF_FN_NONE = 4'h0, PMF_FN_LOCKOUT = 4'h1, PMF_FN_ZERO = 4'h2, PMF_FN_RESET = 4'h3,
        PMF_FN_HOLD = 4'h4, PMF_FN_DSTEP = 4'h5, PMF_FN_ISTEP = 4'h6, PMF_FN_CLR1 = 4'h7,
        PMF_FN_CLR2 = 4'h8, PMF_FN_CLR12 = 4'h9
    } pmf_ufn_t;
    typedef struct packed {
        logic param_key;
        logic sel_key;
        logic clr_key;
    } pmf_keys_t;
    typedef struct packed {
        logic               valid;
        logic signed [17:0] value;
    } pmf_sample_t;
endpackage : pmf_pkg

// File: logic/pmf_top.sv
// Front panel menu, reading filter, scaling and user input of the process meter
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "pmf_consts.svh"
module pmf_top #(
    parameter int          DATA_W        = 18,
    parameter logic [31:0] SCROLL_CYCLES = 32'(`PMF_SCROLL_MS * `PMF_CLK_KHZ),
    parameter logic [31:0] DEB_CYCLES    = 32'(`PMF_DEBOUNCE_MS * `PMF_CLK_KHZ),
    parameter logic [31:0] RPT_DELAY     = 32'(`PMF_RPT_DELAY_MS * `PMF_CLK_KHZ),
    parameter logic [31:0] RPT_PERIOD    = 32'(`PMF_RPT_PERIOD_MS * `PMF_CLK_KHZ),
    parameter logic [31:0] BLINK_CYCLES  = 32'(`PMF_BLINK_MS * `PMF_CLK_KHZ)
) (
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // Front keys and user contact
    input  wire pmf_pkg::pmf_keys_t  keys,
    input  wire logic                user_in,
    // Converted input reading
    input  wire pmf_pkg::pmf_sample_t sample,
    // Display and outputs
    output logic signed [17:0]       disp_value,
    output logic [1:0]               disp_sel,
    output pmf_pkg::pmf_mode_t       mode,
    output logic [2:0]               module_idx,
    output logic [1:0]               param_idx,
    output logic [2:0]               digit_pos,
    output logic                     prompt_phase,
    output logic [1:0]               intensity,
    output logic                     nvm_write,
    output logic [1:0]               sp_clear,
    output logic [1:0]               value_reset
);
    import pmf_pkg::*;

    if (DATA_W != 18) begin : g_bad_width
        $error("pmf_top supports DATA_W of 18 only");
    end
    if (RPT_PERIOD == 0 || RPT_PERIOD > RPT_DELAY || DEB_CYCLES == 0) begin : g_bad_time
        $error("pmf_top timing parameters out of range");
    end

    typedef logic signed [17:0] val_t;
    typedef logic signed [39:0] wide_t;

    function automatic wide_t sx(input val_t v);
        return {{22{v[17]}}, v};
    endfunction : sx

    function automatic val_t lim_lo(input logic [3:0] i);
        case (i)
            `PMF_P_OFFSET: return -18'sd`PMF_OFS_LIM;
            `PMF_P_SDISP1, `PMF_P_SDISP2: return 18'(`PMF_DISP_MIN);
            `PMF_P_INTENS: return 18'sd1;
            default: return 18'sd0;
        endcase
    endfunction : lim_lo

    function automatic val_t lim_hi(input logic [3:0] i);
        case (i)
            `PMF_P_LEVEL, `PMF_P_UASSIGN, `PMF_P_INTENS: return 18'sd3;
            `PMF_P_BAND: return 18'sd`PMF_BAND_MAX;
            `PMF_P_OFFSET: return 18'sd`PMF_OFS_LIM;
            `PMF_P_SIN1, `PMF_P_SIN2: return 18'sd`PMF_IN_MAX;
            `PMF_P_SDISP1, `PMF_P_SDISP2: return 18'sd`PMF_DISP_MAX;
            `PMF_P_UFN: return 18'sd9;
            `PMF_P_DMASK: return 18'sd7;
            default: return 18'sd1;
        endcase
    endfunction : lim_hi

    function automatic val_t clamp(input logic [3:0] i, input val_t v);
        if (v < lim_lo(i)) return lim_lo(i);
        if (v > lim_hi(i)) return lim_hi(i);
        return v;
    endfunction : clamp

    function automatic logic is_numeric(input logic [3:0] i);
        return i == `PMF_P_BAND || i == `PMF_P_OFFSET || (i >= `PMF_P_SIN1 && i <= `PMF_P_SDISP2);
    endfunction : is_numeric

    // Digit wraps 9 to 0 without carry, so other digits stay put
    function automatic val_t bump_digit(input val_t v, input logic [2:0] pos);
        logic [16:0] m;
        logic [16:0] pw;
        logic [16:0] dg;
        m  = v[17] ? 17'(-v) : v[16:0];
        pw = 17'd1;
        for (int k = 0; k < 4; k++) begin
            if (3'(k) < pos) pw = 17'(pw * 17'd10);
        end
        dg = (m / pw) % 17'd10;
        m  = (dg == 17'd9) ? 17'(m - 17'(pw * 17'd9)) : 17'(m + pw);
        return v[17] ? -$signed({1'b0, m}) : $signed({1'b0, m});
    endfunction : bump_digit

    function automatic logic [1:0] next_disp(input logic [1:0] cur, input logic [2:0] mask);
        logic [1:0] n;
        n = cur;
        for (int k = 2; k >= 1; k--) begin
            if (mask[(32'(cur) + k) % 3]) n = 2'((32'(cur) + k) % 3);
        end
        return n;
    endfunction : next_disp

    // Configuration store, shared by bus and panel
    val_t cfg_r [16];
    wire [1:0] level     = cfg_r[`PMF_P_LEVEL][1:0];
    wire val_t band      = cfg_r[`PMF_P_BAND];
    wire val_t offset    = cfg_r[`PMF_P_OFFSET];
    wire live_style      = cfg_r[`PMF_P_STYLE][0];
    wire pmf_ufn_t ufn   = pmf_ufn_t'(cfg_r[`PMF_P_UFN][3:0]);
    wire [1:0] uassign   = cfg_r[`PMF_P_UASSIGN][1:0];
    wire [2:0] dmask     = cfg_r[`PMF_P_DMASK][2:0] | 3'h1;

    // Bus slave: zero wait states, address phase latched for writes
    logic        wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] rdata_nxt;
    wire         addr_ok  = hsel && hready && htrans[1];
    wire         bus_wr   = wr_pend_r && wr_addr_r[11:6] == `PMF_REG_CFG_BASE >> 6;
    wire [3:0]   bus_idx  = wr_addr_r[5:2];
    wire [3:0]   rd_idx   = haddr[5:2];

    pmf_mode_t   mode_nxt;
    val_t        edit_r;
    logic        hold_r;
    logic [3:0]  status_lo;
    assign status_lo = {hold_r, 1'b0, mode};

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (haddr[11:6] == `PMF_REG_CFG_BASE >> 6)
            rdata_nxt = {{14{cfg_r[rd_idx][17]}}, cfg_r[rd_idx]};
        else if (haddr[11:0] == `PMF_REG_STATUS)
            rdata_nxt = {16'h0000, intensity, disp_sel, param_idx, module_idx, digit_pos, status_lo};
        else if (haddr[11:0] == `PMF_REG_DISPLAY)
            rdata_nxt = {{14{disp_value[17]}}, disp_value};
        else if (haddr[11:0] == `PMF_REG_EDIT)
            rdata_nxt = {{14{edit_r[17]}}, edit_r};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            wr_addr_r <= haddr[11:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite) hrdata <= rdata_nxt;
        end
    end

    // Key edges and clear-key auto repeat
    logic [2:0]  key_q_r;
    logic [31:0] rpt_cnt_r;
    wire p_press = keys.param_key && !key_q_r[2];
    wire s_press = keys.sel_key && !key_q_r[1];
    wire rpt_hit = keys.clr_key && rpt_cnt_r == RPT_DELAY;
    wire c_press = (keys.clr_key && !key_q_r[0]) || rpt_hit;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_q_r   <= 3'h0;
            rpt_cnt_r <= 32'h0000_0000;
        end else begin
            key_q_r   <= keys;
            rpt_cnt_r <= !keys.clr_key ? 32'h0000_0000 : rpt_hit ? 32'(RPT_DELAY - RPT_PERIOD) : rpt_cnt_r + 32'h1;
        end
    end

    // User input: synchroniser, debounce, polarity, edge
    logic        us1_r, us2_r, udb_r, uact_q_r;
    logic [31:0] deb_cnt_r;
    wire uact  = udb_r ~^ cfg_r[`PMF_P_UPOL][0];
    wire uedge = uact && !uact_q_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            us1_r     <= 1'b0;
            us2_r     <= 1'b0;
            udb_r     <= 1'b0;
            uact_q_r  <= 1'b0;
            deb_cnt_r <= 32'h0000_0000;
        end else begin
            us1_r     <= user_in;
            us2_r     <= us1_r;
            deb_cnt_r <= (us2_r == udb_r) ? 32'h0000_0000 : deb_cnt_r + 32'h1;
            if (us2_r != udb_r && deb_cnt_r >= DEB_CYCLES - 32'h1) udb_r <= us2_r;
            uact_q_r  <= uact;
        end
    end

    wire input_shown = mode == PMF_DISP && disp_sel == 2'd0;
    wire zero_act    = uedge && input_shown && (ufn == PMF_FN_ZERO ||
                       (ufn == PMF_FN_RESET && uassign == 2'd0));
    wire locked      = cfg_r[`PMF_P_LOCK][0] || (ufn == PMF_FN_LOCKOUT && uact);

    // Scaling and filtering of each new sample
    val_t  filt_r;
    wire wide_t num    = (sx(sample.value) - sx(cfg_r[`PMF_P_SIN1])) *
                         (sx(cfg_r[`PMF_P_SDISP2]) - sx(cfg_r[`PMF_P_SDISP1]));
    wire wide_t den    = sx(cfg_r[`PMF_P_SIN2]) - sx(cfg_r[`PMF_P_SIN1]);
    wire wide_t line_v = sx(cfg_r[`PMF_P_SDISP1]) + ((den == 0) ? 40'sd0 : num / den);
    wire wide_t scaled = line_v + sx(offset);
    wire val_t  scl_c  = scaled < sx(18'(`PMF_DISP_MIN)) ? 18'(`PMF_DISP_MIN) :
                         scaled > sx(18'sd`PMF_DISP_MAX) ? 18'sd`PMF_DISP_MAX : scaled[17:0];
    wire wide_t diff   = sx(scl_c) - sx(filt_r);
    wire wide_t adiff  = diff < 0 ? -diff : diff;
    wire        bypass = band != 0 && adiff > sx(band);
    wire val_t  filt_nxt = (level == 2'd0 || bypass) ? scl_c :
                           18'(sx(filt_r) + (diff >>> ({1'b0, level} + 3'd1)));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) filt_r <= 18'sd0;
        else if (sample.valid) filt_r <= filt_nxt;
    end

    // Menu machine
    logic [31:0] scroll_cnt_r, blink_cnt_r;
    logic        live_r;
    wire  [3:0]  pidx     = {module_idx[1:0], param_idx};
    wire         at_end   = module_idx == 3'(`PMF_NUM_MODULES);
    wire         last_par = param_idx == 2'(`PMF_PARAMS_PER_MOD - 1);
    wire         apply_in = live_style && (pidx == `PMF_P_SIN1 || pidx == `PMF_P_SIN2);
    wire         p_store  = mode == PMF_PARAM && p_press;
    wire         l_store  = mode == PMF_PARAM && apply_in && live_r && s_press;
    wire         scroll_t = cfg_r[`PMF_P_SCROLL][0] && scroll_cnt_r >= SCROLL_CYCLES - 32'h1;
    wire         dstep    = mode == PMF_DISP && (s_press || scroll_t ||
                            (uedge && ufn == PMF_FN_DSTEP));
    wire val_t   step_v   = (edit_r >= lim_hi(pidx)) ? lim_lo(pidx) : 18'(edit_r + 18'sd1);

    always_comb begin
        mode_nxt = mode;
        unique case (mode)
            PMF_DISP:  if (p_press && !locked) mode_nxt = PMF_MENU;
            PMF_MENU:  if (p_press) mode_nxt = at_end ? PMF_DISP : PMF_PARAM;
            PMF_PARAM: if (p_press && last_par) mode_nxt = PMF_MENU;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode         <= PMF_DISP;
            module_idx   <= 3'd0;
            param_idx    <= 2'd0;
            digit_pos    <= 3'd0;
            edit_r       <= 18'sd0;
            live_r       <= 1'b0;
            nvm_write    <= 1'b0;
            prompt_phase <= 1'b0;
            blink_cnt_r  <= 32'h0000_0000;
        end else begin
            mode        <= mode_nxt;
            nvm_write   <= mode == PMF_MENU && p_press && at_end;
            blink_cnt_r <= (blink_cnt_r >= BLINK_CYCLES - 32'h1) ? 32'h0000_0000 : blink_cnt_r + 32'h1;
            if (blink_cnt_r >= BLINK_CYCLES - 32'h1) prompt_phase <= !prompt_phase;
            if (mode_nxt == PMF_DISP) begin
                module_idx <= 3'd0;
            end else if (mode == PMF_MENU && s_press) begin
                module_idx <= at_end ? 3'd0 : module_idx + 3'd1;
            end
            if (mode_nxt == PMF_PARAM && (mode != PMF_PARAM || p_press)) begin
                param_idx <= (mode == PMF_PARAM) ? param_idx + 2'd1 : 2'd0;
                edit_r    <= cfg_r[(mode == PMF_PARAM) ? 4'(pidx + 4'd1) : {module_idx[1:0], 2'd0}];
                digit_pos <= 3'd0;
                live_r    <= 1'b0;
            end else if (mode == PMF_PARAM && live_r) begin
                edit_r <= sample.value;
                if (s_press) live_r <= 1'b0;
            end else if (mode == PMF_PARAM && apply_in) begin
                if (c_press) live_r <= 1'b1;
            end else if (mode == PMF_PARAM && is_numeric(pidx)) begin
                if (c_press) edit_r <= bump_digit(edit_r, digit_pos);
                if (s_press) digit_pos <= (digit_pos == 3'd4) ? 3'd0 : digit_pos + 3'd1;
            end else if (mode == PMF_PARAM && (s_press || c_press)) begin
                edit_r <= step_v;
            end
        end
    end

    // Config writes: bus first, then panel store, then user input actions
    for (genvar i = 0; i < 16; i++) begin : g_cfg
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cfg_r[i] <= (i == `PMF_P_SIN2) ? `PMF_RST_SIN2 : (i == `PMF_P_SDISP2) ? `PMF_RST_SDISP2 :
                            (i == `PMF_P_UPOL || i == `PMF_P_DMASK) ? 18'sd1 :
                            (i == `PMF_P_INTENS) ? 18'sd3 : 18'sd0;
            end else if (bus_wr && bus_idx == 4'(i)) begin
                cfg_r[i] <= clamp(4'(i), hwdata[17:0]);
            end else if ((p_store || l_store) && pidx == 4'(i)) begin
                cfg_r[i] <= clamp(4'(i), l_store ? sample.value : edit_r);
            end else if (zero_act && i == `PMF_P_OFFSET) begin
                cfg_r[i] <= clamp(4'(i), 18'(sx(offset) - sx(disp_value)));
            end else if (uedge && ufn == PMF_FN_ISTEP && i == `PMF_P_INTENS) begin
                cfg_r[i] <= (cfg_r[i] >= 18'sd3) ? 18'sd1 : 18'(cfg_r[i] + 18'sd1);
            end
        end
    end

    // Display selection, hold, output pulses
    wire hold_now = ufn == PMF_FN_HOLD && uact && uassign == 2'd0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            disp_sel     <= 2'd0;
            scroll_cnt_r <= 32'h0000_0000;
            hold_r       <= 1'b0;
            disp_value   <= 18'sd0;
            intensity    <= 2'd3;
            sp_clear     <= 2'b00;
            value_reset  <= 2'b00;
        end else begin
            scroll_cnt_r <= (scroll_t || s_press || mode != PMF_DISP) ? 32'h0000_0000 : scroll_cnt_r + 32'h1;
            if (dstep) disp_sel <= next_disp(disp_sel, dmask);
            hold_r    <= hold_now;
            intensity <= cfg_r[`PMF_P_INTENS][1:0];
            if (mode != PMF_DISP) disp_value <= edit_r;
            else if (!hold_now) disp_value <= filt_r;
            sp_clear[0] <= uedge && (ufn == PMF_FN_CLR1 || ufn == PMF_FN_CLR12);
            sp_clear[1] <= uedge && (ufn == PMF_FN_CLR2 || ufn == PMF_FN_CLR12);
            value_reset <= (uedge && ufn == PMF_FN_RESET) ? (uassign & 2'b11) >> 0 & {2{uassign != 2'd0}} : 2'b00;
        end
    end

endmodule : pmf_top

// File: verification/pmf_assertions.sv
// Port checker for the panel meter block
`timescale 1ns/100ps
module pmf_chk (
    // Clock and reset
    input wire logic                 hclk,
    input wire logic                 hresetn,
    // Observed ports
    input wire pmf_pkg::pmf_keys_t   keys,
    input wire pmf_pkg::pmf_mode_t   mode,
    input wire logic [2:0]           module_idx,
    input wire logic [1:0]           param_idx,
    input wire logic [2:0]           digit_pos,
    input wire logic [1:0]           disp_sel,
    input wire logic [1:0]           intensity,
    input wire logic                 nvm_write,
    input wire logic [1:0]           sp_clear
);
    import pmf_pkg::*;
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_disp_frozen: assert property (
        mode == PMF_DISP && $past(mode) == PMF_DISP |-> $stable(module_idx) && $stable(param_idx))
        else $error("indices moved in display mode");
    a_menu_step: assert property (
        mode == PMF_MENU && $rose(keys.sel_key) && module_idx < 3'h4 |=> module_idx == $past(module_idx) + 3'h1)
        else $error("select did not step module");
    a_module_enter: assert property (
        mode == PMF_MENU && $rose(keys.param_key) && module_idx < 3'h4
        |=> mode == PMF_PARAM && param_idx == 2'h0 && digit_pos == 3'h0)
        else $error("module entry wrong");
    a_param_next: assert property (
        mode == PMF_PARAM && $rose(keys.param_key) && param_idx < 2'h3
        |=> mode == PMF_PARAM && param_idx == $past(param_idx) + 2'h1)
        else $error("parameter did not advance");
    a_module_done: assert property (
        mode == PMF_PARAM && $rose(keys.param_key) && param_idx == 2'h3 |=> mode == PMF_MENU)
        else $error("no return to module prompt");
    a_exit_commit: assert property (
        mode == PMF_MENU && $rose(keys.param_key) && module_idx == 3'h4 |=> nvm_write && mode == PMF_DISP)
        else $error("exit without commit");
    a_commit_pulse: assert property (nvm_write |=> !nvm_write)
        else $error("commit pulse too long");
    a_clear_pulse: assert property (sp_clear != 2'h0 |=> sp_clear == 2'h0)
        else $error("output clear pulse too long");
    a_intens_range: assert property (intensity != 2'h0)
        else $error("intensity level zero");
    a_sel_range: assert property (disp_sel != 2'h3)
        else $error("display select out of range");
    cover property (nvm_write);
    cover property (sp_clear == 2'h3);
    cover property (mode == PMF_PARAM && digit_pos == 3'h1);
endmodule : pmf_chk
bind pmf_top pmf_chk u_chk (.hclk, .hresetn, .keys, .mode, .module_idx, .param_idx, .digit_pos, .disp_sel,
    .intensity, .nvm_write, .sp_clear);

// File: verification/pmf_panel.sv
// Front panel keys and user contact model
`timescale 1ns/100ps
module pmf_panel (
    // Clock
    input wire logic            hclk,
    // Toward the meter
    output pmf_pkg::pmf_keys_t  keys,
    output logic                user_in
);
    import pmf_pkg::*;
    initial begin
        keys    = '0;
        user_in = 1'b0;
    end
    // Two edges low after release, so the next press is a fresh rise
    task automatic press(input int k);
        @(posedge hclk) keys[k] <= 1'b1;
        repeat (2) @(posedge hclk);
        keys[k] <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask : press
    task automatic contact(input logic v, input int n);
        @(posedge hclk) user_in <= v;
        repeat (n) @(posedge hclk);
    endtask : contact
endmodule : pmf_panel

// File: verification/pmf_top_tb.sv
// Self-checking bench for the panel meter block
`timescale 1ns/100ps
`include "pmf_consts.svh"
module pmf_top_tb;
    import pmf_pkg::*;
    logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, user_in, nvm_write, grab, nvm_seen;
    logic [1:0]         htrans, disp_sel, param_idx, intensity, sp_clear, value_reset, clr_seen, rst_seen;
    logic [2:0]         hsize, module_idx, digit_pos;
    logic [31:0]        haddr, hwdata, hrdata;
    logic signed [17:0] disp_value;
    logic               prompt_phase;
    pmf_keys_t          keys;
    pmf_sample_t        sample;
    pmf_mode_t          mode;
    int                 n_fail, tests_run;
    // Short counts keep the run brief
    pmf_top #(.SCROLL_CYCLES(32'h32), .DEB_CYCLES(32'h3), .RPT_DELAY(32'h14), .RPT_PERIOD(32'h5),
        .BLINK_CYCLES(32'h8)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .keys, .user_in, .sample, .disp_value, .disp_sel,
        .mode, .module_idx, .param_idx, .digit_pos, .prompt_phase, .intensity, .nvm_write, .sp_clear,
        .value_reset);
    pmf_panel P (.hclk, .keys, .user_in);
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // One-cycle pulses are gathered over a window
    always @(posedge hclk) begin
        clr_seen <= grab ? clr_seen | sp_clear : 2'h0;
        rst_seen <= grab ? rst_seen | value_reset : 2'h0;
        nvm_seen <= grab ? nvm_seen | nvm_write : 1'b0;
    end
    task automatic stop_test;
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(nm, e, x);
    endtask : rc
    function automatic logic [11:0] ca(input logic [3:0] i);
        return `PMF_REG_CFG_BASE + {6'h0, i, 2'h0};
    endfunction : ca
    // Display settles within a bounded wait after one reading
    task automatic smp(input int v, input int e);
        int i;
        @(posedge hclk) sample <= {1'b1, 18'(v)};
        @(posedge hclk) sample.valid <= 1'b0;
        for (i = 0; i < 20 && disp_value !== 18'(e); i++) @(posedge hclk);
        chk("display", {14'h0, 18'(e)}, {14'h0, disp_value});
    endtask : smp
    task automatic uev(input logic [3:0] fn, input logic a, input int w, input logic [1:0] ec, input logic [1:0] er);
        wr(ca(`PMF_P_UFN), {28'h0, fn});
        grab = 1'b1;
        P.contact(a, w);
        P.contact(~a, 12);
        chk("sp clear", {30'h0, ec}, {30'h0, clr_seen});
        chk("value reset", {30'h0, er}, {30'h0, rst_seen});
        grab = 1'b0;
    endtask : uev
    task automatic t_regs;
        rc("sin2 reset", ca(`PMF_P_SIN2), 32'h3E8);
        rc("pol reset", ca(`PMF_P_UPOL), 32'h1);
        wr(12'h100, 32'h5);
        rc("unmapped", 12'h100, 32'h0);
        wr(ca(`PMF_P_BAND), 32'h1F4);
        rc("band clamp", ca(`PMF_P_BAND), 32'hC7);
        wr(ca(`PMF_P_SDISP1), 32'h186A0);
        rc("sdisp clamp", ca(`PMF_P_SDISP1), 32'h1869F);
        wr(ca(`PMF_P_SIN2), 32'h7530);
        rc("sin2 clamp", ca(`PMF_P_SIN2), 32'h752F);
        wr(ca(`PMF_P_OFFSET), 32'hFFFFB1E0);
        rc("offset clamp", ca(`PMF_P_OFFSET), 32'hFFFFB1E1);
    endtask : t_regs
    task automatic t_filt;
        int l;
        wr(ca(`PMF_P_SDISP1), 32'h0);
        wr(ca(`PMF_P_SIN2), 32'h3E8);
        wr(ca(`PMF_P_OFFSET), 32'h0);
        wr(ca(`PMF_P_BAND), 32'h0);
        for (l = 0; l < 4; l++) begin
            wr(ca(`PMF_P_LEVEL), 32'h0);
            smp(0, 0);
            wr(ca(`PMF_P_LEVEL), 32'(l));
            smp(160, (l == 0) ? 160 : 160 >> (l + 1));
        end
        wr(ca(`PMF_P_BAND), 32'h64);
        smp(192, 192);
        smp(224, 194);
        wr(ca(`PMF_P_LEVEL), 32'h0);
        wr(ca(`PMF_P_BAND), 32'h0);
        wr(ca(`PMF_P_OFFSET), 32'h32);
        smp(100, 150);
        wr(ca(`PMF_P_OFFSET), 32'h0);
        wr(ca(`PMF_P_SDISP2), 32'h7D0);
        smp(1500, 3000);
        smp(-500, -1000);
        wr(ca(`PMF_P_SDISP2), 32'h3E8);
    endtask : t_filt
    task automatic t_menu;
        int i;
        wr(ca(`PMF_P_LOCK), 32'h1);
        P.press(2);
        chk("locked", {30'h0, PMF_DISP}, {30'h0, mode});
        wr(ca(`PMF_P_LOCK), 32'h0);
        P.press(2);
        P.press(1);
        chk("module", 32'h1, {29'h0, module_idx});
        i = prompt_phase;
        repeat (8) @(posedge hclk);
        chk("blink", 32'(!i), {31'h0, prompt_phase});
        P.press(2);
        P.press(0);
        chk("digit inc", 32'h1, {14'h0, disp_value});
        P.press(1);
        chk("digit pos", 32'h1, {29'h0, digit_pos});
        P.press(0);
        chk("digit two", 32'hB, {14'h0, disp_value});
        repeat (4) P.press(2);
        chk("module prompt", {30'h0, PMF_MENU}, {30'h0, mode});
        rc("stored", ca(`PMF_P_SIN1), 32'hB);
        rc("kept", ca(`PMF_P_SIN2), 32'h3E8);
        for (i = 0; i < 8 && module_idx !== 3'h4; i++) P.press(1);
        grab = 1'b1;
        P.press(2);
        chk("exit", {30'h0, PMF_DISP}, {30'h0, mode});
        chk("commit", 32'h1, {31'h0, nvm_seen});
        grab = 1'b0;
        wr(ca(`PMF_P_SIN1), 32'h0);
    endtask : t_menu
    task automatic t_user;
        int i;
        wr(ca(`PMF_P_UASSIGN), 32'h2);
        uev(PMF_FN_CLR1, 1'b1, 8, 2'h1, 2'h0);
        uev(PMF_FN_CLR2, 1'b1, 8, 2'h2, 2'h0);
        uev(PMF_FN_CLR12, 1'b1, 8, 2'h3, 2'h0);
        uev(PMF_FN_RESET, 1'b1, 8, 2'h0, 2'h2);
        uev(PMF_FN_CLR1, 1'b1, 1, 2'h0, 2'h0);
        uev(PMF_FN_NONE, 1'b1, 8, 2'h0, 2'h0);
        P.contact(1'b1, 12);
        wr(ca(`PMF_P_UPOL), 32'h0);
        uev(PMF_FN_CLR1, 1'b0, 8, 2'h1, 2'h0);
        wr(ca(`PMF_P_UFN), 32'h0);
        wr(ca(`PMF_P_UPOL), 32'h1);
        P.contact(1'b0, 12);
        wr(ca(`PMF_P_INTENS), 32'h1);
        uev(PMF_FN_ISTEP, 1'b1, 8, 2'h0, 2'h0);
        chk("intensity", 32'h2, {30'h0, intensity});
        wr(ca(`PMF_P_DMASK), 32'h3);
        uev(PMF_FN_DSTEP, 1'b1, 8, 2'h0, 2'h0);
        chk("display step", 32'h1, {30'h0, disp_sel});
        P.press(1);
        chk("select key", 32'h0, {30'h0, disp_sel});
        wr(ca(`PMF_P_SCROLL), 32'h1);
        for (i = 0; i < 80 && disp_sel === 2'h0; i++) @(posedge hclk);
        chk("scroll", 32'h1, {30'h0, disp_sel});
        wr(ca(`PMF_P_SCROLL), 32'h0);
        uev(PMF_FN_ZERO, 1'b1, 8, 2'h0, 2'h0);
        rc("zero off input", ca(`PMF_P_OFFSET), 32'h0);
        wr(ca(`PMF_P_UASSIGN), 32'h0);
        wr(ca(`PMF_P_UFN), {28'h0, PMF_FN_HOLD});
        P.contact(1'b1, 8);
        smp(500, -1000);
        rc("hold", `PMF_REG_DISPLAY, 32'hFFFFFC18);
        P.contact(1'b0, 12);
        P.press(1);
        smp(300, 300);
        uev(PMF_FN_ZERO, 1'b1, 8, 2'h0, 2'h0);
        rc("zero offset", ca(`PMF_P_OFFSET), 32'hFFFFFED4);
    endtask : t_user
    initial begin
        #400000;
        n_fail++;
        stop_test;
    end
    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        haddr   = 32'h0;
        hwdata  = 32'h0;
        sample  = '0;
        grab    = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_filt;
        t_menu;
        t_user;
        stop_test;
    end
endmodule : pmf_top_tb
